// File: mcs_pkg.sv
/*
 Constants for the module management control and status sequencer.
 Assumes a 100 MHz system clock; times are given in their own unit.
*/
`default_nettype none
package mcs_pkg;
  localparam int unsigned MCS_CLK_MHZ = 100;
  // Least low time of the module reset pin that counts as a reset
  localparam int unsigned MCS_RESET_PULSE_NS = 2000;
  localparam int unsigned MCS_RESET_PULSE_CYC =
    (MCS_RESET_PULSE_NS * MCS_CLK_MHZ + 999) / 1000;
  // Longest initialization time, power-on or reset to fully functional
  localparam int unsigned MCS_INIT_MS = 2000;
  localparam int unsigned MCS_INIT_CYC = MCS_INIT_MS * 1000 * MCS_CLK_MHZ;
  // Flag bit positions
  localparam int unsigned MCS_FLAG_READY = 0;
  localparam int unsigned MCS_FLAG_LOS = 1;
  localparam int unsigned MCS_FLAG_TXF = 2;
  localparam int unsigned MCS_FLAG_OTHER = 3;
  localparam int unsigned MCS_NUM_FLAGS = 8;
  // Pin synchroniser lanes
  localparam int unsigned MCS_PIN_RST = 0;
  localparam int unsigned MCS_PIN_LP = 1;
  localparam int unsigned MCS_PIN_SEL = 2;
  localparam int unsigned MCS_PIN_SCL = 3;
  localparam int unsigned MCS_NUM_PINS = 4;
  localparam logic [3:0] MCS_PINS_RESET = 4'hd;
  localparam logic [31:0] MCS_CNT_ZERO = 32'h0;
  typedef enum logic [1:0] {
    MCS_ST_RESET = 2'b00,
    MCS_ST_INIT = 2'b01,
    MCS_ST_READY = 2'b10
  } mcs_state_t;
endpackage : mcs_pkg
`default_nettype wire

// File: mcs_ctrl_status.sv
/*
 Control and status sequencing of a pluggable transceiver's management
 logic: initialization, module reset pin, low power, module select,
 latched flags with masks and the open-drain interrupt output.
 Assumes a two-wire bus engine on clk_sys that reports stop bits and the
 values carried by each write or read; the bus clock pin is sampled here.
*/
`timescale 1ns/1ps
`default_nettype none
module mcs_ctrl_status
  import mcs_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = mcs_pkg::MCS_INIT_CYC,
  parameter int unsigned NUM_OTHER = mcs_pkg::MCS_NUM_FLAGS - 3
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Module pins
  input wire logic module_reset_n,
  input wire logic low_power_pin,
  input wire logic module_select_n,
  input wire logic bus_clk_pin,
  output logic interrupt_out_n,
  // Module internal conditions, on clk_sys
  input wire logic rx_los_cond,
  input wire logic tx_fault_cond,
  input wire logic [NUM_OTHER-1:0] other_cond,
  // Two-wire bus engine, on clk_sys
  input wire logic wr_stop,
  input wire logic [mcs_pkg::MCS_NUM_FLAGS-1:0] wr_mask,
  input wire logic wr_power_down,
  input wire logic rd_stop,
  input wire logic [mcs_pkg::MCS_NUM_FLAGS-1:0] rd_clear,
  output logic bus_respond,
  // Status
  output logic [mcs_pkg::MCS_NUM_FLAGS-1:0] flags,
  output logic [mcs_pkg::MCS_NUM_FLAGS-1:0] masks,
  output logic data_not_ready,
  output logic power_down,
  output logic low_power,
  output logic fully_functional
);
  import mcs_pkg::*;

  localparam int unsigned NF = MCS_NUM_FLAGS;

  // Timing budget: the pin and bus responses are due within tens of
  // microseconds or more, while this logic answers within a few clk_sys
  // cycles. So no response timers are kept, apart from the init count
  // and the reset pulse qualifier, which must really last.
  //
  // Hazard: every pin is asynchronous to clk_sys, so logic reads only the
  // second flip-flop of its synchroniser, never the first.
  //
  // Limitation: a reset pin pulse shorter than the qualifier is ignored
  // entirely. A pulse just over it costs a full initialization.

  logic [MCS_NUM_PINS-1:0] pin_meta_reg;
  logic [MCS_NUM_PINS-1:0] pin_sync_reg;
  logic scl_prev_reg;
  logic scl_fall;
  logic [31:0] rlow_cnt_reg;
  logic soft_reset;
  mcs_state_t state_reg;
  logic [31:0] init_cnt_reg;
  logic [NF-1:0] flags_reg;
  logic [NF-1:0] flag_set;
  logic [NF-1:0] cond_now;
  logic [NF-1:0] cond_prev_reg;
  logic [NF-1:0] mask_reg;
  logic [NF-1:0] mask_pend_reg;
  logic [NF-1:0] clr_pend_reg;
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic pdown_reg;
  logic pdown_pend_reg;
  logic int_n_reg;
  logic dnr_reg;
  logic respond_reg;
  logic lp_reg;

  // Two-flip-flop synchronisers for every pin
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_meta_reg <= MCS_PINS_RESET;
      pin_sync_reg <= MCS_PINS_RESET;
    end else begin
      pin_meta_reg <= {bus_clk_pin, module_select_n, low_power_pin,
                       module_reset_n};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Falling edge of the sampled bus clock
  // The previous value resets to the idle high level of the pin, so the
  // first sample after reset cannot be taken as a false falling edge.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scl_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= pin_sync_reg[MCS_PIN_SCL];
    end
  end
  assign scl_fall = scl_prev_reg & ~pin_sync_reg[MCS_PIN_SCL];

  // Reset pin low-time qualifier; shorter glitches are ignored
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rlow_cnt_reg <= MCS_CNT_ZERO;
    end else if (pin_sync_reg[MCS_PIN_RST]) begin
      rlow_cnt_reg <= MCS_CNT_ZERO;
    end else if (rlow_cnt_reg < MCS_RESET_PULSE_CYC) begin
      rlow_cnt_reg <= rlow_cnt_reg + 32'h1;
    end
  end
  // Held in reset while the pin stays low past the least pulse time
  assign soft_reset = (rlow_cnt_reg >= MCS_RESET_PULSE_CYC) |
                      (state_reg == MCS_ST_RESET &&
                       !pin_sync_reg[MCS_PIN_RST]);

  // Initialization sequencer: reset, init count, ready
  // The sequencer waits in the reset state for as long as the pin stays
  // low. It counts the init time from the first cycle after the pin has
  // risen, so a long pulse never eats into the init budget.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= MCS_ST_INIT;
      init_cnt_reg <= MCS_CNT_ZERO;
    end else if (soft_reset) begin
      state_reg <= MCS_ST_RESET;
      init_cnt_reg <= MCS_CNT_ZERO;
    end else begin
      case (state_reg)
        MCS_ST_RESET: begin
          state_reg <= MCS_ST_INIT;
        end
        MCS_ST_INIT: begin
          if (init_cnt_reg >= INIT_CYCLES - 1) begin
            state_reg <= MCS_ST_READY;
          end else begin
            init_cnt_reg <= init_cnt_reg + 32'h1;
          end
        end
        default: begin
          state_reg <= MCS_ST_READY;
        end
      endcase
    end
  end

  // Data-not-ready stays set until initialization ends
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dnr_reg <= 1'b1;
    end else begin
      dnr_reg <= (state_reg != MCS_ST_READY);
    end
  end

  // Condition vector; the ready flag rises when data-not-ready clears
  always_comb begin
    cond_now = '0;
    cond_now[MCS_FLAG_READY] = (state_reg == MCS_ST_READY);
    cond_now[MCS_FLAG_LOS] = rx_los_cond;
    cond_now[MCS_FLAG_TXF] = tx_fault_cond;
    cond_now[NF-1:MCS_FLAG_OTHER] = other_cond;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cond_prev_reg <= '0;
    end else if (soft_reset) begin
      cond_prev_reg <= '0;
    end else begin
      cond_prev_reg <= cond_now;
    end
  end
  assign flag_set = cond_now & ~cond_prev_reg;

  // Host transactions wait for the bus clock fall after their stop bit
  // A second stop of the same kind before that fall replaces its pending values:
  // only the latest write and the latest read are applied, as the host last saw them.
  // A stop in the same cycle as a fall stays pending for the next fall.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      mask_pend_reg <= '0;
      pdown_pend_reg <= 1'b0;
      clr_pend_reg <= '0;
    end else begin
      if (wr_stop) begin
        wr_pend_reg <= 1'b1;
        mask_pend_reg <= wr_mask;
        pdown_pend_reg <= wr_power_down;
      end else if (scl_fall) begin
        wr_pend_reg <= 1'b0;
      end
      if (rd_stop) begin
        rd_pend_reg <= 1'b1;
        clr_pend_reg <= rd_clear;
      end else if (scl_fall) begin
        rd_pend_reg <= 1'b0;
      end
    end
  end

  // Latched flags; a new event wins over a clear in the same cycle
  // Flags latch on the rising edge of their condition only. A condition
  // that stays high after a clear does not latch again, so the host is
  // not flooded with interrupts by one long fault.
  // Masked flags still latch; the mask only gates the interrupt.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flags_reg <= '0;
    end else if (soft_reset) begin
      flags_reg <= '0;
    end else if (rd_pend_reg && scl_fall) begin
      flags_reg <= (flags_reg & ~clr_pend_reg) | flag_set;
    end else begin
      flags_reg <= flags_reg | flag_set;
    end
  end

  // Mask and power-down bits take effect at the clock fall after stop
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mask_reg <= '0;
      pdown_reg <= 1'b0;
    end else if (soft_reset) begin
      mask_reg <= '0;
      pdown_reg <= 1'b0;
    end else if (wr_pend_reg && scl_fall) begin
      mask_reg <= mask_pend_reg;
      pdown_reg <= pdown_pend_reg;
    end
  end

  // Interrupt low while any unmasked flag is latched
  // Registered so the open-drain pin never glitches low on a decode.
  // A value of one means the pin is released to its pull-up.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      int_n_reg <= 1'b1;
    end else begin
      int_n_reg <= ~|(flags_reg & ~mask_reg);
    end
  end

  // Bus answers once ready and while the module is selected
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      respond_reg <= 1'b0;
    end else begin
      respond_reg <= (state_reg == MCS_ST_READY) &
                     ~pin_sync_reg[MCS_PIN_SEL];
    end
  end

  // Lower power level from the pin or the power-down bit
  // Either source alone is enough; the lower level is left only when
  // the pin is low and the power-down bit is clear.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lp_reg <= 1'b0;
    end else begin
      lp_reg <= pin_sync_reg[MCS_PIN_LP] | pdown_reg;
    end
  end

  assign interrupt_out_n = int_n_reg;
  assign bus_respond = respond_reg;
  assign flags = flags_reg;
  assign masks = mask_reg;
  assign data_not_ready = dnr_reg;
  assign power_down = pdown_reg;
  assign low_power = lp_reg;
  // Ready state reached and data-not-ready has cleared
  assign fully_functional = ~dnr_reg & (state_reg == MCS_ST_READY);
endmodule // mcs_ctrl_status
`default_nettype wire

// File: mcs_ctrl_status_assertions.sv
/* Port timing checker for the control and status sequencer.
   Assumes it is bound to every mcs_ctrl_status instance. */
`timescale 1ns/1ps
`default_nettype none
module mcs_ctrl_status_assertions
  import mcs_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = 50,
  parameter int unsigned NUM_OTHER = 5
) (
  // Clock, reset and pins
  input wire logic clk_sys, rst, module_reset_n,
  input wire logic low_power_pin, module_select_n, interrupt_out_n,
  // Conditions
  input wire logic rx_los_cond, tx_fault_cond,
  input wire logic [NUM_OTHER-1:0] other_cond,
  // Status
  input wire logic bus_respond, data_not_ready, power_down,
  input wire logic low_power, fully_functional,
  input wire logic [7:0] flags, masks
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [31:0] wait_cnt;
  logic [7:0] live;
  // Flags that may pull the interrupt low
  assign live = flags & ~masks;
  // Cycles spent short of fully functional since a reset ended
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) wait_cnt <= 32'h0;
    else if (fully_functional || !module_reset_n) wait_cnt <= 32'h0;
    else wait_cnt <= wait_cnt + 32'h1;
  end
  // Selected while ready, and deselected, for long enough to sync
  sequence s_sel_on;
    (fully_functional && !module_select_n)[*5];
  endsequence
  sequence s_sel_off;
    module_select_n[*5];
  endsequence
  a_init_bound: assert property (
    wait_cnt <= INIT_CYCLES + 8)
    else $error("ready state reached too late");
  a_ready_flag: assert property (
    $fell(data_not_ready) |-> flags[0] && fully_functional)
    else $error("ready flag missing");
  a_los_latch: assert property (
    fully_functional && $rose(rx_los_cond) |=> flags[1])
    else $error("loss flag not latched");
  a_txf_latch: assert property (
    fully_functional && $rose(tx_fault_cond) |=> flags[2])
    else $error("fault flag not latched");
  a_other_latch: assert property (
    fully_functional && $rose(other_cond[0]) |=> flags[3])
    else $error("other flag not latched");
  a_int_low: assert property (
    module_reset_n && |live |=> !interrupt_out_n)
    else $error("interrupt not asserted");
  a_int_high: assert property (
    !(|live) |=> interrupt_out_n)
    else $error("interrupt not released");
  a_sel_answer: assert property (
    s_sel_on |-> bus_respond)
    else $error("bus not answered");
  a_sel_quiet: assert property (
    s_sel_off |-> !bus_respond)
    else $error("bus answered while deselected");
  a_lp_pin: assert property (
    low_power_pin[*5] |-> low_power)
    else $error("low power pin ignored");
  a_pdown_power: assert property (
    power_down |=> low_power)
    else $error("power down ignored");
endmodule // mcs_ctrl_status_assertions
bind mcs_ctrl_status mcs_ctrl_status_assertions #(
  .INIT_CYCLES(INIT_CYCLES), .NUM_OTHER(NUM_OTHER)
) i_mcs_ctrl_status_assertions (.*);
`default_nettype wire

// File: mcs_host_model.sv
/* Host side of the two-wire bus: makes the bus clock pin.
   Assumes the bench raises frame_on for the length of a transfer. */
`timescale 1ns/1ps
`default_nettype none
module mcs_host_model (
  // Transfer window
  input wire logic frame_on,
  // Bus clock pin, pulled up while idle
  output logic bus_clk
);
  // 80 ns clock inside frames only, phase unrelated to clk_sys
  initial begin
    bus_clk = 1'h1;
    #13;
    forever begin
      #40;
      bus_clk = frame_on ? ~bus_clk : 1'h1;
    end
  end
endmodule // mcs_host_model
`default_nettype wire

// File: mcs_ctrl_status_tb.sv
/* Self-checking bench for the control and status sequencer.
   Assumes the host model supplies the bus clock pin. */
`timescale 1ns/1ps
`default_nettype none
module mcs_ctrl_status_tb;
  import mcs_pkg::*;
  logic clk_sys, rst, module_reset_n, low_power_pin, module_select_n;
  logic bus_clk_pin, interrupt_out_n, rx_los_cond, tx_fault_cond;
  logic wr_stop, wr_power_down, rd_stop, bus_respond, frame_on;
  logic data_not_ready, power_down, low_power, fully_functional;
  logic [4:0] other_cond;
  logic [7:0] wr_mask, rd_clear, flags, masks;
  int failures, checked, cycles;
  mcs_ctrl_status #(.INIT_CYCLES(50), .NUM_OTHER(5)) i_mcs_ctrl_status (.*);
  mcs_host_model i_mcs_host_model (.frame_on(frame_on), .bus_clk(bus_clk_pin));
  // System clock
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      failures++;
      results();
    end
  end
  // Compare and count
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One read or write: stop pulse, then a short bus clock frame
  task automatic bus_op(logic wr, logic [7:0] val, logic pd);
    @(negedge clk_sys);
    wr_stop = wr; rd_stop = !wr; wr_mask = val; rd_clear = val;
    wr_power_down = pd;
    @(negedge clk_sys);
    wr_stop = 1'h0; rd_stop = 1'h0; frame_on = 1'h1;
    repeat (17) @(negedge clk_sys);
    frame_on = 1'h0;
    repeat (20) @(negedge clk_sys);
  endtask
  task automatic wait_ff();
    repeat (100) begin
      if (fully_functional === 1'h1) break;
      @(negedge clk_sys);
    end
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic t_init();
    wait_ff();
    chk({flags, 5'h0, fully_functional, data_not_ready, interrupt_out_n},
      16'h0104);
    bus_op(1'h0, 8'h01, 1'h0);
    chk({flags, 7'h0, interrupt_out_n}, 16'h0001);
    $display("init test done");
  endtask
  task automatic t_flags();
    rx_los_cond = 1'h1; tx_fault_cond = 1'h1; other_cond = 5'h01;
    repeat (3) @(negedge clk_sys);
    chk({flags, 7'h0, interrupt_out_n},
      16'h0e00);
    bus_op(1'h0, 8'h02, 1'h0);
    chk({flags, 7'h0, interrupt_out_n}, 16'h0c00);
    bus_op(1'h0, 8'h0c, 1'h0);
    chk({flags, 7'h0, interrupt_out_n}, 16'h0001);
    rx_los_cond = 1'h0; tx_fault_cond = 1'h0; other_cond = 5'h00;
    $display("flag test done");
  endtask
  task automatic t_mask();
    bus_op(1'h1, 8'h02, 1'h0);
    rx_los_cond = 1'h1;
    repeat (3) @(negedge clk_sys);
    chk({flags, masks}, 16'h0202);
    chk({15'h0, interrupt_out_n}, 16'h0001);
    bus_op(1'h1, 8'h00, 1'h0);
    chk({masks, 7'h0, interrupt_out_n}, 16'h0000);
    bus_op(1'h0, 8'h02, 1'h0);
    rx_los_cond = 1'h0;
    $display("mask test done");
  endtask
  task automatic t_pins();
    bus_op(1'h1, 8'h00, 1'h1);
    chk({13'h0, power_down, low_power, fully_functional}, 16'h7);
    bus_op(1'h1, 8'h00, 1'h0);
    chk({13'h0, power_down, low_power, fully_functional}, 16'h1);
    low_power_pin = 1'h1;
    repeat (6) @(negedge clk_sys);
    chk({15'h0, low_power}, 16'h1);
    low_power_pin = 1'h0; module_select_n = 1'h1;
    repeat (6) @(negedge clk_sys);
    chk({15'h0, bus_respond}, 16'h0);
    module_select_n = 1'h0;
    repeat (6) @(negedge clk_sys);
    chk({15'h0, bus_respond}, 16'h1);
    $display("pin test done");
  endtask
  task automatic t_reset_pin();
    other_cond = 5'h02;
    @(negedge clk_sys);
    module_reset_n = 1'h0;
    repeat (100) @(negedge clk_sys);
    module_reset_n = 1'h1;
    repeat (10) @(negedge clk_sys);
    chk({flags, 6'h0, fully_functional, interrupt_out_n}, 16'h1002);
    module_reset_n = 1'h0;
    repeat (250) @(negedge clk_sys);
    chk({flags, 6'h0, fully_functional, interrupt_out_n}, 16'h0001);
    module_reset_n = 1'h1;
    wait_ff();
    chk({15'h0, fully_functional}, 16'h1);
    $display("reset pin test done");
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    rst = 1'h1; module_reset_n = 1'h1; low_power_pin = 1'h0;
    module_select_n = 1'h0; rx_los_cond = 1'h0; tx_fault_cond = 1'h0;
    other_cond = 5'h00; wr_stop = 1'h0; rd_stop = 1'h0; frame_on = 1'h0;
    wr_power_down = 1'h0; wr_mask = 8'h00; rd_clear = 8'h00;
    repeat (4) @(negedge clk_sys);
    rst = 1'h0;
    t_init();
    t_flags();
    t_mask();
    t_pins();
    t_reset_pin();
    results();
  end
endmodule // mcs_ctrl_status_tb
`default_nettype wire
